// [phy_glue.sv]
// phy board glue: management slave, register file, leds, ref clock, skew
`default_nettype none
module phy_glue
    import phy_glue_pkg::*;
(
    input wire logic clk_sys, // shared oscillator derived clock
    input wire logic rst,
    input wire logic phy_hw_reset_n, // host driven hardware reset
    input wire logic mdc, // management clock pin
    input wire logic mdio_i, // management data in
    output logic mdio_o, // management data out
    output logic mdio_oe, // high while driving
    input wire line_stat_s line_in, // line side status
    input wire logic tx_clk_in, // transmit clock
    input wire logic rx_clk_in, // receive clock
    input wire logic skew_en, // insert interface clock skew
    output logic tx_clk_skew,
    output logic rx_clk_skew,
    output logic derived_ref_clock_out,
    output logic link_indicator,
    output logic activity_indicator,
    output logic phy_irq_n,
    output logic link_up,
    output logic [15:0] ctrl_reg_out
);
    // pin synchronisers
    logic [1:0] mdc_s_r, mdio_s_r, hrst_s_r, par_s_r, eee_s_r, trf_s_r;
    // two flops each
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mdc_s_r <= 2'h0;
            mdio_s_r <= 2'h0;
            hrst_s_r <= 2'h0;
            par_s_r <= 2'h0;
            eee_s_r <= 2'h0;
            trf_s_r <= 2'h0;
        end else begin
            mdc_s_r <= {mdc_s_r[0], mdc};
            mdio_s_r <= {mdio_s_r[0], mdio_i};
            hrst_s_r <= {hrst_s_r[0], phy_hw_reset_n};
            par_s_r <= {par_s_r[0], line_in.partner};
            eee_s_r <= {eee_s_r[0], line_in.eee};
            trf_s_r <= {trf_s_r[0], line_in.traffic};
        end
    end
    logic mdc_d_r; // previous synced mdc
    logic mdc_rise, mdc_fall;
    logic hrst; // internal hardware reset
    logic soft_rst;
    assign mdc_rise = mdc_s_r[1] && !mdc_d_r;
    assign mdc_fall = !mdc_s_r[1] && mdc_d_r;
    assign hrst = rst || !hrst_s_r[1] || soft_rst;
    // mdc edge history
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mdc_d_r <= 1'b0;
        end else begin
            mdc_d_r <= mdc_s_r[1];
        end
    end
    // management frame parser
    mdio_st_e st_r;
    logic [5:0] bcnt_r; // bit counter
    logic [15:0] sh_r; // header / data shift
    logic [4:0] reg_sel_r; // addressed register
    logic [15:0] rd_sh_r; // read data shift
    logic req_valid_r;
    mgmt_req_s req_r;
    logic buf_in_ready;
    logic [15:0] rd_val; // register read mux
    // serial frame engine, samples data on mdc rising edges
    always_ff @(posedge clk_sys) begin
        if (hrst) begin
            st_r <= M_PRE;
            bcnt_r <= 6'h00;
            sh_r <= 16'h0000;
            reg_sel_r <= 5'h00;
            req_valid_r <= 1'b0;
            req_r <= '0;
        end else begin
            if (req_valid_r && buf_in_ready) begin
                req_valid_r <= 1'b0;
            end
            if (mdc_rise) begin
                case (st_r)
                    M_PRE: begin // count ones, then start 01
                        if (mdio_s_r[1]) begin
                            bcnt_r <= (bcnt_r == 6'(MDIO_PRE_LEN)) ? bcnt_r : bcnt_r + 6'h01;
                        end else if (bcnt_r == 6'(MDIO_PRE_LEN)) begin
                            st_r <= M_HDR;
                            bcnt_r <= 6'h00;
                        end else begin
                            bcnt_r <= 6'h00;
                        end
                    end
                    M_HDR: begin // start bit 1, op 2, phy 5, reg 5
                        sh_r <= {sh_r[14:0], mdio_s_r[1]};
                        bcnt_r <= bcnt_r + 6'h01;
                        if (bcnt_r == 6'h0C) begin
                            // bits: [12]=start1 [11:10]=op [9:5]=phy [4:0]=reg
                            if (sh_r[8:4] != PHY_ADDR) begin
                                st_r <= M_IDLE;
                            end else begin
                                reg_sel_r <= {sh_r[3:0], mdio_s_r[1]};
                                st_r <= M_TA;
                            end
                            bcnt_r <= 6'h00;
                        end
                    end
                    M_TA: begin // turnaround two bits
                        bcnt_r <= bcnt_r + 6'h01;
                        if (bcnt_r == 6'h01) begin
                            st_r <= (sh_r[11:10] == 2'b01) ? M_WDAT : M_RDAT;
                            bcnt_r <= 6'h00;
                        end
                    end
                    M_WDAT: begin // sixteen write bits
                        sh_r <= {sh_r[14:0], mdio_s_r[1]};
                        bcnt_r <= bcnt_r + 6'h01;
                        if (bcnt_r == 6'h0F) begin
                            req_valid_r <= 1'b1;
                            req_r <= '{wr: 1'b1, reg_addr: reg_sel_r, data: {sh_r[14:0], mdio_s_r[1]}};
                            st_r <= M_PRE;
                            bcnt_r <= 6'h00;
                        end
                    end
                    M_RDAT: begin // sixteen read bits driven
                        bcnt_r <= bcnt_r + 6'h01;
                        if (bcnt_r == 6'h0F) begin
                            st_r <= M_PRE;
                            bcnt_r <= 6'h00;
                        end
                    end
                    M_IDLE: begin // not ours: wait out 18 bits
                        bcnt_r <= bcnt_r + 6'h01;
                        if (bcnt_r == 6'h11) begin
                            st_r <= M_PRE;
                            bcnt_r <= 6'h00;
                        end
                    end
                    default: st_r <= M_PRE;
                endcase
            end
        end
    end
    // read data drive: load at turnaround, shift on falling edges
    always_ff @(posedge clk_sys) begin
        if (hrst) begin
            rd_sh_r <= 16'h0000;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
        end else if (mdc_fall) begin
            if (st_r == M_TA && bcnt_r == 6'h01 && sh_r[11:10] == 2'b10) begin
                mdio_oe <= 1'b1; // second turnaround bit driven low
                mdio_o <= 1'b0;
                rd_sh_r <= rd_val;
            end else if (st_r == M_RDAT) begin
                mdio_o <= rd_sh_r[15];
                rd_sh_r <= {rd_sh_r[14:0], 1'b0};
            end else begin
                mdio_oe <= 1'b0;
                mdio_o <= 1'b0;
            end
        end
    end
    // write requests pass a two-entry buffer
    logic bo_valid;
    mgmt_req_s bo_data;
    mgmt_buf2 u_buf (
        .clk_sys(clk_sys),
        .rst(hrst),
        .in_valid(req_valid_r),
        .in_ready(buf_in_ready),
        .in_data(req_r),
        .out_valid(bo_valid),
        .out_ready(1'b1),
        .out_data(bo_data)
    );
    // register file
    logic [15:0] ctrl_r, anadv_r, gctrl_r, inten_r, intst_r;
    logic link_r, andone_r;
    assign soft_rst = ctrl_r[CTRL_RESET_BIT];
    // writable registers, defaults advertise every speed
    always_ff @(posedge clk_sys) begin
        if (rst || !hrst_s_r[1]) begin
            ctrl_r <= CTRL_RST;
            anadv_r <= ANADV_RST;
            gctrl_r <= GCTRL_RST;
            inten_r <= INTEN_RST;
        end else if (ctrl_r[CTRL_RESET_BIT]) begin
            ctrl_r <= CTRL_RST; // self clearing soft reset
        end else if (bo_valid && bo_data.wr) begin
            case (bo_data.reg_addr)
                REG_CTRL: ctrl_r <= bo_data.data;
                REG_ANADV: anadv_r <= bo_data.data;
                REG_GCTRL: gctrl_r <= bo_data.data;
                REG_INTEN: inten_r <= bo_data.data;
                default: ; // read only or absent
            endcase
        end
    end
    // read mux, unmapped reads as zero
    always_comb begin
        case (reg_sel_r)
            REG_CTRL: rd_val = ctrl_r;
            REG_STAT: rd_val = STAT_BASE | (16'(link_r) << STAT_LINK_BIT) | (16'(andone_r) << STAT_ANDONE_BIT);
            REG_ID1: rd_val = ID1_VAL;
            REG_ID2: rd_val = ID2_VAL;
            REG_ANADV: rd_val = anadv_r;
            REG_GCTRL: rd_val = gctrl_r;
            REG_INTEN: rd_val = inten_r;
            REG_INTST: rd_val = intst_r;
            default: rd_val = 16'h0000;
        endcase
    end
    // autonomous link: follows partner when autoneg enabled
    always_ff @(posedge clk_sys) begin
        if (hrst) begin
            link_r <= 1'b0;
            andone_r <= 1'b0;
        end else begin
            link_r <= par_s_r[1] && ctrl_r[CTRL_ANEN_BIT];
            andone_r <= par_s_r[1] && ctrl_r[CTRL_ANEN_BIT];
        end
    end
    // link change status, set wins over read clear
    logic rd_intst;
    assign rd_intst = mdc_fall && st_r == M_TA && bcnt_r == 6'h01 && sh_r[11:10] == 2'b10 && reg_sel_r == REG_INTST;
    always_ff @(posedge clk_sys) begin
        if (hrst) begin
            intst_r <= 16'h0000;
        end else begin
            intst_r <= (rd_intst ? 16'h0000 : intst_r) | {5'h00, (link_r != andone_r) || (link_r != link_up), 10'h000};
        end
    end
    // active low interrupt
    always_ff @(posedge clk_sys) begin
        if (hrst) begin
            phy_irq_n <= 1'b1;
        end else begin
            phy_irq_n <= !(|(intst_r & inten_r));
        end
    end
    // leds: steady link, eee blink, activity blink
    logic [31:0] lcnt_r, acnt_r;
    logic eee_ph_r, act_ph_r;
    always_ff @(posedge clk_sys) begin
        if (hrst || !link_r || !eee_s_r[1]) begin
            lcnt_r <= 32'h0;
            eee_ph_r <= 1'b1;
        end else if (lcnt_r == 32'(eee_ph_r ? LINK_ON_CYC - 1 : LINK_OFF_CYC - 1)) begin
            lcnt_r <= 32'h0;
            eee_ph_r <= !eee_ph_r;
        end else begin
            lcnt_r <= lcnt_r + 32'h1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (hrst || !trf_s_r[1]) begin
            acnt_r <= 32'h0;
            act_ph_r <= 1'b0;
        end else if (acnt_r == 32'(ACT_CYC - 1)) begin
            acnt_r <= 32'h0;
            act_ph_r <= !act_ph_r;
        end else begin
            acnt_r <= acnt_r + 32'h1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (hrst) begin
            link_indicator <= 1'b0;
            activity_indicator <= 1'b0;
            link_up <= 1'b0;
            ctrl_reg_out <= CTRL_RST;
        end else begin
            link_indicator <= link_r && (!eee_s_r[1] || eee_ph_r);
            activity_indicator <= trf_s_r[1] && !act_ph_r;
            link_up <= link_r;
            ctrl_reg_out <= ctrl_r;
        end
    end
    // reference clock toggles every cycle, held low in reset
    always_ff @(posedge clk_sys) begin
        if (hrst) begin
            derived_ref_clock_out <= 1'b0;
        end else begin
            derived_ref_clock_out <= !derived_ref_clock_out;
        end
    end
    // skewed interface clocks: pins pass three flops, skew adds one more stage
    logic [2:0] txs_r, rxs_r;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txs_r <= 3'h0;
            rxs_r <= 3'h0;
            tx_clk_skew <= 1'b0;
            rx_clk_skew <= 1'b0;
        end else begin
            txs_r <= {txs_r[1:0], tx_clk_in};
            rxs_r <= {rxs_r[1:0], rx_clk_in};
            tx_clk_skew <= skew_en ? txs_r[2] : txs_r[1];
            rx_clk_skew <= skew_en ? rxs_r[2] : rxs_r[1];
        end
    end
    // assertions
    ref_stops_a: assert property (@(posedge clk_sys) !hrst_s_r[1] |=> !derived_ref_clock_out)
        else $error("ref clock ran during reset");
    link_steady_a: assert property (@(posedge clk_sys) disable iff (hrst)
        (link_r && !eee_s_r[1]) ##1 (link_r && !eee_s_r[1]) |-> link_indicator)
        else $error("link led not steady");
    nolink_dark_a: assert property (@(posedge clk_sys) disable iff (hrst) !link_r |=> !link_indicator)
        else $error("link led lit without link");
    link_follow_a: assert property (@(posedge clk_sys) disable iff (hrst)
        (par_s_r[1] && ctrl_r[CTRL_ANEN_BIT]) |=> link_r)
        else $error("link not autonomous");
    act_quiet_a: assert property (@(posedge clk_sys) disable iff (hrst) !trf_s_r[1] |=> !activity_indicator)
        else $error("activity without traffic");
    irq_gate_a: assert property (@(posedge clk_sys) disable iff (hrst) (inten_r == 16'h0) |=> phy_irq_n)
        else $error("masked interrupt asserted");
    addr_filter_a: assert property (@(posedge clk_sys) disable iff (hrst)
        (mdc_rise && st_r == M_HDR && bcnt_r == 6'h0C && sh_r[8:4] != PHY_ADDR) |=> st_r == M_IDLE)
        else $error("foreign address accepted");
    eee_on_a: assert property (@(posedge clk_sys) disable iff (hrst)
        (link_r && eee_s_r[1] && !eee_ph_r) |=> !link_indicator)
        else $error("eee off phase lit");
    defaults_a: assert property (@(posedge clk_sys) $fell(rst) |-> ctrl_r[CTRL_ANEN_BIT] && gctrl_r == GCTRL_RST)
        else $error("autoneg defaults wrong");
    skew_on_a: assert property (@(posedge clk_sys) disable iff (rst) skew_en |=> tx_clk_skew == $past(txs_r[2]))
        else $error("skew path wrong");
endmodule : phy_glue
`default_nettype wire

// [phy_glue_pkg.sv]
// package: constants and types for the phy board glue block
`default_nettype none
package phy_glue_pkg;
    localparam int CLK_MHZ = 125; // system clock rate
    localparam int LINK_ON_MS = 400; // eee blink on time
    localparam int LINK_OFF_MS = 2000; // eee blink off time
    localparam int ACT_BLINK_MS = 50; // activity blink half period
    localparam int SKEW_PS = 2000; // interface clock skew
    localparam int CYC_PER_MS = CLK_MHZ * 1000; // cycles per millisecond
    localparam int LINK_ON_CYC = LINK_ON_MS * CYC_PER_MS;
    localparam int LINK_OFF_CYC = LINK_OFF_MS * CYC_PER_MS;
    localparam int ACT_CYC = ACT_BLINK_MS * CYC_PER_MS;
    localparam int SKEW_CYC = (SKEW_PS + 7999) / 8000; // rounds up to one cycle
    localparam int REF_DIV = 1; // 62.5 MHz ref from 125 MHz clock: toggle each cycle
    localparam logic [4:0] PHY_ADDR = 5'h01; // management address
    // standard register indices
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h01;
    localparam logic [4:0] REG_ID1 = 5'h02;
    localparam logic [4:0] REG_ID2 = 5'h03;
    localparam logic [4:0] REG_ANADV = 5'h04;
    localparam logic [4:0] REG_GCTRL = 5'h09;
    localparam logic [4:0] REG_INTEN = 5'h12;
    localparam logic [4:0] REG_INTST = 5'h13;
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h1140; // autoneg on, 1000 full
    localparam logic [15:0] ANADV_RST = 16'h01E1; // 10/100 half+full
    localparam logic [15:0] GCTRL_RST = 16'h0200; // 1000 full
    localparam logic [15:0] INTEN_RST = 16'h0000;
    localparam logic [15:0] STAT_BASE = 16'h7949; // abilities, ext caps
    localparam logic [15:0] ID1_VAL = 16'h1234; // arbitrary identity value
    localparam logic [15:0] ID2_VAL = 16'h5670; // arbitrary identity value
    localparam int CTRL_RESET_BIT = 15;
    localparam int CTRL_ANEN_BIT = 12;
    localparam int STAT_LINK_BIT = 2;
    localparam int STAT_ANDONE_BIT = 5;
    localparam int MDIO_PRE_LEN = 32; // preamble ones
    // management frame fields after parse
    typedef struct packed {
        logic wr; // write op
        logic [4:0] reg_addr; // register index
        logic [15:0] data; // write data
    } mgmt_req_s;
    // line side status
    typedef struct packed {
        logic partner; // capable partner present
        logic eee; // energy efficient idle
        logic traffic; // frame activity
    } line_stat_s;
    // management slave states
    typedef enum logic [5:0] {
        M_PRE = 6'h01,
        M_HDR = 6'h02,
        M_TA = 6'h04,
        M_WDAT = 6'h08,
        M_RDAT = 6'h10,
        M_IDLE = 6'h20
    } mdio_st_e;
endpackage : phy_glue_pkg
`default_nettype wire

// [mgmt_buf2.sv]
// two-entry valid/ready buffer for management requests
`default_nettype none
module mgmt_buf2
    import phy_glue_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire mgmt_req_s in_data,
    output logic out_valid,
    input wire logic out_ready,
    output mgmt_req_s out_data
);
    mgmt_req_s mem_r [2]; // storage
    logic wp_r; // write pointer
    logic rp_r; // read pointer
    logic [1:0] cnt_r; // fill level
    logic push;
    logic pop;
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // storage write
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
    // pointers and count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
    buf_bound_a: assert property (@(posedge clk_sys) disable iff (rst) cnt_r <= 2'h2)
        else $error("buffer overfilled");
endmodule : mgmt_buf2
`default_nettype wire

// [mgmt_master_model.sv]
// management bus master model driving clause 22 frames on a slow link clock
`default_nettype none
module mgmt_master_model (
    output var logic mdc, // link clock, stands low between frames
    output var logic m_o, // master data bit
    output var logic m_oe, // high while the master drives the line
    input wire logic mdio // resolved line level
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: clock still, line released to its pull-up
    initial begin
        mdc = 1'b0;
        m_o = 1'b0;
        m_oe = 1'b0;
    end
    // one whole frame of 64 bit slots, data set while the clock is low
    task automatic frame(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] seq;
        seq = {32'hFFFFFFFF, 2'b01, (wr ? 2'b01 : 2'b10), pa, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            m_o = seq[63 - i];
            m_oe = wr || (i < 46); // read: let go from turnaround on
            #62.5 mdc = 1'b1;
            if (i >= 48) begin
                rd[63 - i] = mdio; // msb first, taken on the rise
            end
            #62.5 mdc = 1'b0;
        end
        m_oe = 1'b0; // release so the pull-up wins
    endtask : frame
endmodule : mgmt_master_model
`default_nettype wire

// [tb_phy_glue.sv]
// self-checking bench for the phy board glue block
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_phy_glue
    import phy_glue_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0] ra; // register index
        logic [15:0] exp; // value after reset
    } row_s;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic phy_hw_reset_n = 1'b1; // active low pin
    logic mdc, m_o, m_oe, mdio_o, mdio_oe;
    wire logic mdio_line; // resolved management line
    logic tx_clk_in = 1'b0;
    logic rx_clk_in = 1'b0;
    logic skew_en = 1'b0;
    logic tx_clk_skew, rx_clk_skew, derived_ref_clock_out;
    logic link_indicator, activity_indicator, phy_irq_n, link_up;
    logic [15:0] ctrl_reg_out, rd;
    line_stat_s line_in = '0;
    int error_cnt = 0;
    int samples_checked = 0;
    int d0, d1;
    logic a;
    row_s rows [6] = '{'{REG_CTRL, CTRL_RST}, '{REG_ANADV, ANADV_RST}, '{REG_GCTRL, GCTRL_RST},
                       '{REG_ID1, ID1_VAL}, '{REG_ID2, ID2_VAL}, '{REG_INTEN, INTEN_RST}};
    // pull-up wins when nobody drives
    assign mdio_line = mdio_oe ? mdio_o : (m_oe ? m_o : 1'b1);
    // system clock, 8 ns period
    always #4 clk_sys = ~clk_sys;
    mgmt_master_model i_mdm (.mdc(mdc), .m_o(m_o), .m_oe(m_oe), .mdio(mdio_line));
    phy_glue i_dut (.clk_sys(clk_sys), .rst(rst), .phy_hw_reset_n(phy_hw_reset_n), .mdc(mdc),
        .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .line_in(line_in),
        .tx_clk_in(tx_clk_in), .rx_clk_in(rx_clk_in), .skew_en(skew_en), .tx_clk_skew(tx_clk_skew),
        .rx_clk_skew(rx_clk_skew), .derived_ref_clock_out(derived_ref_clock_out),
        .link_indicator(link_indicator), .activity_indicator(activity_indicator),
        .phy_irq_n(phy_irq_n), .link_up(link_up), .ctrl_reg_out(ctrl_reg_out));
    // verdict and end of run
    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    // one management frame, then let the write settle
    task automatic mg(input logic wr, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
        i_mdm.frame(wr, pa, ra, wd, rd);
        repeat (8) @(posedge clk_sys);
        #1;
    endtask : mg
    // edges from an interface clock rise to the delayed copy rising
    task automatic meas(input logic en, output int d);
        @(posedge clk_sys);
        #1 skew_en = en;
        tx_clk_in = 1'b0;
        rx_clk_in = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 tx_clk_in = 1'b1;
        rx_clk_in = 1'b1;
        d = 0;
        while (tx_clk_skew !== 1'b1 && d < 20) begin
            @(posedge clk_sys);
            #1 d++;
        end
        `CHK("rx_skew_follows", 1'b1, rx_clk_skew)
    endtask : meas
    // wait for link_up to reach a level, bounded
    task automatic wait_link(input logic lv);
        for (int k = 0; k < 300 && link_up !== lv; k++) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : wait_link
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        `CHK("ref_clk_in_reset", 1'b0, derived_ref_clock_out)
        `CHK("ctrl_after_reset", CTRL_RST, ctrl_reg_out)
        `CHK("irq_after_reset", 1'b1, phy_irq_n)
        rst = 1'b0;
        repeat (6) @(posedge clk_sys);
        for (int i = 0; i < 6; i++) begin
            mg(1'b0, PHY_ADDR, rows[i].ra, 16'h0000);
            `CHK("reg_reset_value", rows[i].exp, rd)
        end
        mg(1'b0, 5'h02, REG_CTRL, 16'h0000);
        `CHK("stray_read", 16'hFFFF, rd)
        mg(1'b1, 5'h00, REG_CTRL, 16'h0140);
        `CHK("stray_write", CTRL_RST, ctrl_reg_out)
        mg(1'b1, PHY_ADDR, REG_ANADV, 16'h0061);
        mg(1'b0, PHY_ADDR, REG_ANADV, 16'h0000);
        `CHK("adv_readback", 16'h0061, rd)
        mg(1'b1, PHY_ADDR, REG_ID1, 16'hFFFF);
        mg(1'b0, PHY_ADDR, REG_ID1, 16'h0000);
        `CHK("id_read_only", ID1_VAL, rd)
        // partner attaches with no host setup of the link
        mg(1'b1, PHY_ADDR, REG_INTEN, 16'h0400);
        @(posedge clk_sys);
        #1 line_in.partner = 1'b1;
        wait_link(1'b1);
        `CHK("link_up", 1'b1, link_up)
        repeat (100) @(posedge clk_sys);
        #1;
        `CHK("link_led_steady", 1'b1, link_indicator)
        `CHK("act_led_quiet", 1'b0, activity_indicator)
        `CHK("irq_on_link", 1'b0, phy_irq_n)
        // traffic lights the activity led, eee starts in its on phase
        line_in.traffic = 1'b1;
        line_in.eee = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        `CHK("act_led_traffic", 1'b1, activity_indicator)
        `CHK("link_led_eee_on", 1'b1, link_indicator)
        line_in.traffic = 1'b0;
        line_in.eee = 1'b0;
        mg(1'b0, PHY_ADDR, REG_STAT, 16'h0000);
        `CHK("stat_link", 1'b1, rd[STAT_LINK_BIT])
        mg(1'b0, PHY_ADDR, REG_INTST, 16'h0000);
        `CHK("int_status_set", 1'b1, rd[10])
        mg(1'b0, PHY_ADDR, REG_INTST, 16'h0000);
        `CHK("int_status_clear", 1'b0, rd[10])
        `CHK("irq_released", 1'b1, phy_irq_n)
        line_in.partner = 1'b0;
        wait_link(1'b0);
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK("link_led_off", 1'b0, link_indicator)
        // interface clock skew against plain pass
        meas(1'b0, d0);
        meas(1'b1, d1);
        `CHK("skew_delay", d0 + SKEW_CYC, d1)
        // hardware reset stops the reference clock and restores control
        mg(1'b1, PHY_ADDR, REG_CTRL, 16'h0140);
        `CHK("ctrl_written", 16'h0140, ctrl_reg_out)
        @(posedge clk_sys);
        #1 phy_hw_reset_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        a = 1'b0;
        for (int k = 0; k < 16; k++) begin
            @(posedge clk_sys);
            #1 a = a | derived_ref_clock_out;
        end
        `CHK("ref_clk_stopped", 1'b0, a)
        `CHK("ctrl_hw_reset", CTRL_RST, ctrl_reg_out)
        phy_hw_reset_n = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 a = derived_ref_clock_out;
        @(posedge clk_sys);
        #1;
        `CHK("ref_clk_running", ~a, derived_ref_clock_out)
        // reset bit clears itself and control reads back its default
        mg(1'b1, PHY_ADDR, REG_CTRL, 16'h8040);
        mg(1'b0, PHY_ADDR, REG_CTRL, 16'h0000);
        `CHK("ctrl_soft_reset", CTRL_RST, rd)
        report_and_stop();
    end
    // watchdog against a hang
    initial begin
        #500us;
        error_cnt++;
        report_and_stop();
    end
endmodule : tb_phy_glue
`default_nettype wire
